// >>> pkg/hcm_pkg.sv
// package for the hub configuration method selector
package hcm_pkg;

    // ***************************************************************
    // register map, byte addresses
    // ***************************************************************
    localparam logic [7:0] HCM_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] HCM_ADDR_STATUS = 8'h04;
    localparam logic [7:0] HCM_ADDR_INFO   = 8'h08;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int HCM_CTRL_RELATCH  = 0;    // write 1: re-sample straps (pulse)
    localparam int HCM_CTRL_STRAPOVR = 1;    // force strap values from ctrl bits
    localparam int HCM_CTRL_OVR_HI   = 2;
    localparam int HCM_CTRL_OVR_LO   = 3;
    localparam int HCM_ST_METHOD     = 0;    // [1:0]
    localparam int HCM_ST_EXTCLK     = 2;
    localparam int HCM_ST_LOCALPWR   = 3;
    localparam int HCM_ST_SELFPWR    = 4;
    localparam int HCM_ST_GANGED     = 5;
    localparam int HCM_ST_LATCHED    = 6;
    localparam int HCM_INFO_SLVADDR  = 0;    // [6:0]

    // ***************************************************************
    // constants and timing
    // ***************************************************************
    localparam logic [6:0]  HCM_SLAVE_ADDR  = 7'h2c;   // 0101100
    localparam int          HCM_REF_MHZ     = 24;
    localparam int          HCM_CLK_MHZ     = 20;
    localparam int          HCM_RST_MIN_NS  = 1000;    // 1us least reset pulse
    localparam int          HCM_CLK_NS      = 1000 / HCM_CLK_MHZ;
    localparam int          HCM_RST_MIN_CYC = (HCM_RST_MIN_NS + HCM_CLK_NS - 1) / HCM_CLK_NS;
    localparam logic [31:0] HCM_CTRL_RESET  = 32'h0000_0000;

    // ***************************************************************
    // types
    // ***************************************************************
    typedef enum logic [1:0]
    {
        HCM_METHOD_SMBUS,
        HCM_METHOD_DEFAULT,
        HCM_METHOD_EEPROM
    } hcm_method_t;

    typedef struct packed
    {
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hsel;
        logic        hready;
    } hcm_ahb_req_t;

    typedef struct packed
    {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } hcm_ahb_rsp_t;

    typedef struct packed
    {
        logic selfpowered;
        logic ganged_sense;
    } hcm_power_t;

endpackage

// >>> design/hcm_strap_sync.sv
// three-stage pin synchroniser with second/third agreement
`timescale 1ns/1ns
module hcm_strap_sync
#(
    parameter int W = 4
)
(
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // pin side
    input  wire logic [W-1:0] pin_in,
    // synchronous side
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    // stable bits follow once stages two and three agree
    assign out_d   = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
    assign pin_out = out_q;

    // shift chain
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end
        else
        begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end
endmodule

// >>> design/hcm_top.sv
// hub configuration method selector with ahb-lite status port
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - strap_hi low selects management-bus slave mode at address 0101100 regardless of strap_lo.
// - strap_hi high and strap_lo low selects the internal default configuration from straps.
// - both straps high selects loading from an external two-wire serial memory.
// - the device runs from a 24 MHz reference from crystal or external clock.
// - ext_clock_select low uses the crystal, high takes the clock from osc_in_pin.
// - local_power_present low means bus power only, high means local power available.
// - the straps are sampled on the fifth clock edge after reset release, once the synchroniser has settled; method_valid stays low until then.
// - in default mode local power gives self-powered ganged sensing, else bus-powered none.
module hcm_top
    import hcm_pkg::*;
(
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // ahb-lite slave
    input  wire hcm_pkg::hcm_ahb_req_t ahb_req,
    input  wire logic [31:0]   hwdata,
    output hcm_pkg::hcm_ahb_rsp_t      ahb_rsp,
    // strap and detect pins
    input  wire logic          config_method_strap_hi,
    input  wire logic          config_method_strap_lo,
    input  wire logic          ext_clock_select,
    input  wire logic          local_power_present,
    // configuration outputs
    output hcm_pkg::hcm_method_t       method,
    output logic               method_valid,
    output logic               smbus_slave_en,
    output logic [6:0]         smbus_slave_addr,
    output logic               eeprom_load_en,
    output logic               use_defaults,
    output logic               osc_use_crystal,
    output hcm_pkg::hcm_power_t        power_cfg
);
    import hcm_pkg::*;

    // ***************************************************************
    // pin synchronisation
    // ***************************************************************
    logic [3:0] pins_s;
    logic       s_hi;
    logic       s_lo;
    logic       s_ext;
    logic       s_pwr;

    hcm_strap_sync #(.W(4)) u_sync
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  ({config_method_strap_hi, config_method_strap_lo, ext_clock_select, local_power_present}),
        .pin_out (pins_s)
    );

    assign s_hi  = pins_s[3];
    assign s_lo  = pins_s[2];
    assign s_ext = pins_s[1];
    assign s_pwr = pins_s[0];

    // ***************************************************************
    // method decode
    // ***************************************************************
    function automatic hcm_method_t decode_method(input logic hi, input logic lo);
        hcm_method_t m;
        m = HCM_METHOD_SMBUS;
        if (!hi)
            m = HCM_METHOD_SMBUS;
        else if (!lo)
            m = HCM_METHOD_DEFAULT;
        else
            m = HCM_METHOD_EEPROM;
        return m;
    endfunction

    // ***************************************************************
    // strap latch after reset release
    // ***************************************************************
    localparam int SETTLE = 5;                     // three sync stages, agreement stage, latch edge
    logic [2:0]   settle_q;
    logic         latched_q;
    hcm_method_t  method_q;
    logic         relatch_q;
    logic         ovr_en_q;
    logic         ovr_hi_q;
    logic         ovr_lo_q;
    logic         take;
    logic         eff_hi;
    logic         eff_lo;

    assign eff_hi = ovr_en_q ? ovr_hi_q : s_hi;
    assign eff_lo = ovr_en_q ? ovr_lo_q : s_lo;
    assign take   = (!latched_q && (settle_q == 3'(SETTLE - 1))) || relatch_q;

    // settle counter runs once after release
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            settle_q <= '0;
        else if (settle_q != 3'(SETTLE - 1))
            settle_q <= settle_q + 3'h1;
    end

    // latch straps once after release or on a relatch write, otherwise hold until next reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            latched_q <= 1'b0;
            method_q  <= HCM_METHOD_SMBUS;
        end
        else if (take)
        begin
            latched_q <= 1'b1;
            method_q  <= decode_method(eff_hi, eff_lo);
        end
    end

    // ***************************************************************
    // clock and power selection
    // ***************************************************************
    logic pwr_q;
    logic ext_q;

    // live levels of clock select and power detect
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwr_q <= 1'b0;
            ext_q <= 1'b0;
        end
        else
        begin
            pwr_q <= s_pwr;
            ext_q <= s_ext;
        end
    end

    // outputs
    assign method           = method_q;
    assign method_valid     = latched_q;
    assign smbus_slave_en   = latched_q && (method_q == HCM_METHOD_SMBUS);
    assign smbus_slave_addr = HCM_SLAVE_ADDR;
    assign eeprom_load_en   = latched_q && (method_q == HCM_METHOD_EEPROM);
    assign use_defaults     = latched_q && (method_q == HCM_METHOD_DEFAULT);
    assign osc_use_crystal  = !ext_q;
    assign power_cfg.selfpowered  = use_defaults && pwr_q;
    assign power_cfg.ganged_sense = use_defaults && pwr_q;

    // ***************************************************************
    // ahb-lite slave, zero wait state
    // ***************************************************************
    logic        dp_valid_q;
    logic        dp_write_q;
    logic [7:0]  dp_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ap_take;
    logic        wr_ctrl;
    logic [31:0] status_w;

    assign ap_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    assign wr_ctrl = dp_valid_q && dp_write_q && (dp_addr_q == HCM_ADDR_CTRL);
    assign status_w = {25'h0, latched_q, power_cfg.ganged_sense, power_cfg.selfpowered,
                       pwr_q, ext_q, method_q};
    assign rdata_d = (ahb_req.haddr[7:0] == HCM_ADDR_CTRL)   ? {28'h0, ovr_lo_q, ovr_hi_q, ovr_en_q, 1'b0} :
                     (ahb_req.haddr[7:0] == HCM_ADDR_STATUS) ? status_w :
                     (ahb_req.haddr[7:0] == HCM_ADDR_INFO)   ? {25'h0, HCM_SLAVE_ADDR} : 32'h0;
    assign ahb_rsp.hrdata    = rdata_q;
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = 1'b0;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= '0;
            rdata_q    <= '0;
        end
        else if (ahb_req.hready)
        begin
            dp_valid_q <= ap_take;
            dp_write_q <= ahb_req.hwrite;
            dp_addr_q  <= ahb_req.haddr[7:0];
            rdata_q    <= (ap_take && !ahb_req.hwrite) ? rdata_d : 32'h0;
        end
    end

    // control register write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            relatch_q <= HCM_CTRL_RESET[HCM_CTRL_RELATCH];
            ovr_en_q  <= HCM_CTRL_RESET[HCM_CTRL_STRAPOVR];
            ovr_hi_q  <= HCM_CTRL_RESET[HCM_CTRL_OVR_HI];
            ovr_lo_q  <= HCM_CTRL_RESET[HCM_CTRL_OVR_LO];
        end
        else
        begin
            relatch_q <= wr_ctrl && hwdata[HCM_CTRL_RELATCH];
            if (wr_ctrl)
            begin
                ovr_en_q <= hwdata[HCM_CTRL_STRAPOVR];
                ovr_hi_q <= hwdata[HCM_CTRL_OVR_HI];
                ovr_lo_q <= hwdata[HCM_CTRL_OVR_LO];
            end
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    sequence latch_ev_s;
        !latched_q ##1 latched_q;
    endsequence

    latch_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> ##[0:6] latched_q)
        else $error("method not latched soon after reset");

    hold_method_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (latched_q && !relatch_q) |=> $stable(method_q))
        else $error("latched method changed without relatch");

    smbus_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (latch_ev_s ##0 ($past(eff_hi) == 1'b0)) |-> smbus_slave_en && smbus_slave_addr == 7'h2c)
        else $error("strap hi low did not select smbus");

    dflt_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && eff_hi && !eff_lo) |=> use_defaults && !eeprom_load_en)
        else $error("default method not selected");

    eeprom_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && eff_hi && eff_lo) |=> eeprom_load_en && !smbus_slave_en)
        else $error("eeprom method not selected");

    osc_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_ext == 1'b1) |=> !osc_use_crystal)
        else $error("external clock not selected");

    pwr_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (pwr_q == $past(s_pwr)))
        else $error("power detect level not followed");

    dflt_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
        use_defaults |-> (power_cfg.selfpowered == pwr_q) && (power_cfg.ganged_sense == pwr_q))
        else $error("default power options wrong");
endmodule

// >>> sim/hcm_board_model.sv
// board model that pulses the active-low reset pin for the least legal time
`timescale 1ns/1ns
module hcm_board_model
    import hcm_pkg::*;
#(
    parameter int RST_CYC = HCM_RST_MIN_CYC
)
(
    // clock
    input  wire logic hclk,
    // request from the bench
    input  wire logic pulse_req,
    // board side
    output logic      hresetn_pin,
    output logic      busy
);
    import hcm_pkg::*;
    logic [7:0] cnt_q = 8'h00;

    // hold reset low for RST_CYC whole cycles, never shorter
    always @(posedge hclk)
    begin
        if (pulse_req)
            cnt_q <= 8'(RST_CYC);
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end

    // reset pin and busy flag
    assign hresetn_pin = (cnt_q == 8'h00);
    assign busy        = (cnt_q != 8'h00);
endmodule

// >>> sim/hcm_top_test.sv
// self-checking bench for the configuration method selector
`timescale 1ns/1ns
module hcm_top_test;
    import hcm_pkg::*;
    logic hclk = 1'b0, init_rstn = 1'b0, pulse_req = 1'b0, brd_rstn, brd_busy, hresetn;
    logic s_hi = 1'b0, s_lo = 1'b0, lpwr = 1'b0, extc = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0, hsel = 1'b0;
    hcm_ahb_req_t ahb_req;
    hcm_ahb_rsp_t ahb_rsp;
    hcm_method_t method;
    hcm_power_t power_cfg;
    logic method_valid, smb_en, eep_en, use_def, osc_xtal;
    logic [6:0] slv_addr;
    int fails = 0, samples_checked = 0, cycles = 0;
    // rows: strap hi, strap lo, local power, ext clock, expected method
    logic [5:0] rows [6] = '{6'b0000_00, 6'b0111_00, 6'b1010_01, 6'b1001_01, 6'b1110_10, 6'b1101_10};

    // ***************************************************************
    // clock, reset and instances
    // ***************************************************************
    always #25 hclk = ~hclk;
    assign hresetn = init_rstn & brd_rstn;
    assign ahb_req = {haddr, htrans, hwrite, 3'b010, hsel, ahb_rsp.hreadyout};
    hcm_board_model brd (.hclk(hclk), .pulse_req(pulse_req), .hresetn_pin(brd_rstn), .busy(brd_busy));
    hcm_top dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .hwdata(hwdata), .ahb_rsp(ahb_rsp),
        .config_method_strap_hi(s_hi), .config_method_strap_lo(s_lo), .ext_clock_select(extc),
        .local_power_present(lpwr), .method(method), .method_valid(method_valid), .smbus_slave_en(smb_en),
        .smbus_slave_addr(slv_addr), .eeprom_load_en(eep_en), .use_defaults(use_def),
        .osc_use_crystal(osc_xtal), .power_cfg(power_cfg));

    // ***************************************************************
    // tasks
    // ***************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // wait for a rising edge at which hready is sampled high; if it never is, only the hang guard ends this
    task automatic wait_ready();
        @(posedge hclk);
        while (ahb_rsp.hreadyout !== 1'b1)
            @(posedge hclk);
    endtask

    // one single word transfer, read data taken at the edge that ends the data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsel   <= 1'b1;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        r = ahb_rsp.hrdata;
        chk("hresp okay", {31'h0, ahb_rsp.hresp}, 32'h0);
    endtask

    // board reset pulse, then wait for the latch
    task automatic reset_and_latch();
        int n;
        @(posedge hclk);
        pulse_req <= 1'b1;
        @(posedge hclk);
        pulse_req <= 1'b0;
        repeat (5) @(negedge hclk);
        chk("valid in reset", {31'h0, method_valid}, 32'h0);
        n = 0;
        while (brd_busy === 1'b1 && n < 100)
        begin
            @(negedge hclk);
            n++;
        end
        n = 0;
        while (method_valid !== 1'b1 && n < 20)
        begin
            @(negedge hclk);
            n++;
        end
        chk("valid after release", {31'h0, method_valid}, 32'h1);
    endtask

    // ***************************************************************
    // hang guard and main sequence
    // ***************************************************************
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end

    initial
    begin
        logic [5:0] r;
        logic [1:0] m;
        logic sp;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk("reset valid", {31'h0, method_valid}, 32'h0);
        chk("reset crystal", {31'h0, osc_xtal}, 32'h1);
        @(posedge hclk);
        init_rstn <= 1'b1;
        ahb(1'b0, HCM_ADDR_CTRL, 32'h0, rd);
        chk("ctrl reset", rd, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            r = rows[i];
            @(posedge hclk);
            {s_hi, s_lo, lpwr, extc} <= r[5:2];
            reset_and_latch();
            m  = r[1:0];
            sp = (m == 2'd1) & r[3];
            chk("method", {30'h0, method}, {30'h0, m});
            chk("enables", {29'h0, smb_en, eep_en, use_def}, {29'h0, m == 2'd0, m == 2'd2, m == 2'd1});
            chk("power", {30'h0, power_cfg}, {30'h0, sp, sp});
            chk("crystal", {31'h0, osc_xtal}, {31'h0, ~r[2]});
            chk("slave addr", {25'h0, slv_addr}, 32'h0000_002c);
            ahb(1'b0, HCM_ADDR_STATUS, 32'h0, rd);
            chk("status", rd, {25'h0, 1'b1, sp, sp, r[3], r[2], m});
        end
        // straps move after the latch: method holds, clock select follows
        @(posedge hclk);
        {s_hi, s_lo, extc} <= 3'b000;
        repeat (10) @(negedge hclk);
        chk("held method", {30'h0, method}, 32'h2);
        chk("held enable", {31'h0, eep_en}, 32'h1);
        chk("crystal follows", {31'h0, osc_xtal}, 32'h1);
        ahb(1'b0, HCM_ADDR_INFO, 32'h0, rd);
        chk("info", rd, 32'h0000_002c);
        ahb(1'b1, 8'h0c, 32'hffff_ffff, rd);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        // software override with relatch picks default mode; a board reset clears it again
        ahb(1'b1, HCM_ADDR_CTRL, 32'h0000_0007, rd);
        @(negedge hclk);
        @(negedge hclk);
        chk("override method", {30'h0, method}, 32'h1);
        chk("override enables", {29'h0, smb_en, eep_en, use_def}, 32'h1);
        chk("override power", {30'h0, power_cfg}, 32'h0);
        ahb(1'b0, HCM_ADDR_CTRL, 32'h0, rd);
        chk("ctrl override", rd, 32'h0000_0006);
        reset_and_latch();
        chk("method after reset", {30'h0, method}, 32'h0);
        chk("smbus after reset", {29'h0, smb_en, eep_en, use_def}, 32'h4);
        ahb(1'b0, HCM_ADDR_CTRL, 32'h0, rd);
        chk("ctrl after reset", rd, 32'h0);
        close_out();
    end
endmodule
